// ===== hdl/domd_pkg.sv
// Purpose: shared constants and types for the dual opcode map decoder
// Assumes: byte-wide opcode stream from fetch, one byte per cycle at most
// Notes:   region and register encodings used by decoder and address unit
package domd_pkg;
   localparam logic [7:0]  ESCAPE_PREFIX     = 8'ha5;
   localparam logic [7:0]  EXT_FIRST_VALID   = 8'h06;
   localparam logic [7:0]  LEGACY_DIRECT_SFR = 8'h80;
   localparam logic [7:0]  REGION_ZERO       = 8'h00;
   localparam logic [8:0]  SFR_SPACE_LAST    = 9'h1ff;
   localparam logic [5:0]  DWORD_DED_LOW     = 6'h38;
   localparam logic [5:0]  DWORD_DED_HIGH    = 6'h3c;
   localparam logic [5:0]  DWORD_GEN_LAST    = 6'h1c;
   localparam logic [5:0]  WORD_LAST         = 6'h1e;
   localparam logic [5:0]  BANKED_BYTE_LAST  = 6'h07;
   localparam logic [5:0]  BANKED_WORD_LAST  = 6'h06;
   localparam logic [5:0]  BANKED_DWORD_LAST = 6'h02;
   localparam logic [1:0]  BANK_RESET        = 2'h0;
   localparam logic [3:0]  PREFIX_EXTRA_STATE = 4'h1;
   localparam logic [3:0]  SLOW_ACCESS_STATE  = 4'h1;

   typedef enum logic [1:0] {
      MAP_LEGACY_FIRST = 2'h0,
      MAP_EXT_FIRST    = 2'h1
   } domd_map_type;

   typedef enum logic [2:0] {
      GRP_LEGACY_LOW  = 3'h0,
      GRP_LEGACY_HIGH = 3'h1,
      GRP_EXTENSION   = 3'h2,
      GRP_INVALID     = 3'h3
   } domd_group_type;

   typedef enum logic [1:0] {
      WID_BIT   = 2'h0,
      WID_BYTE  = 2'h1,
      WID_WORD  = 2'h2,
      WID_DWORD = 2'h3
   } domd_width_type;

   typedef enum logic [2:0] {
      AM_REGISTER  = 3'h0,
      AM_IMMEDIATE = 3'h1,
      AM_DIRECT    = 3'h2,
      AM_INDIRECT  = 3'h3,
      AM_DISPLACE  = 3'h4,
      AM_RELATIVE  = 3'h5
   } domd_amode_type;

   typedef enum logic [1:0] {
      RK_SHORT_BYTE = 2'h0,
      RK_WIDE_BYTE  = 2'h1,
      RK_WORD       = 2'h2,
      RK_DWORD      = 2'h3
   } domd_regkind_type;
endpackage

// ===== hdl/domd_addr_unit.sv
// Purpose: operand address forming for the dual opcode map decoder
// Assumes: base register contents supplied by the register file
// Notes:   combinational; the main decoder registers the result
`timescale 1ns/1ps
module domd_addr_unit (
   input  wire domd_pkg::domd_amode_type amode,
   input  wire logic                     legacy_op,
   input  wire logic [23:0]              direct_addr,
   input  wire logic [23:0]              base_reg_value,
   input  wire logic [23:0]              offset,
   input  wire logic [23:0]              next_pc,
   output logic      [23:0]              eff_addr,
   output logic                          to_sfr_space
);
   import domd_pkg::*;

   always_comb begin
      eff_addr     = direct_addr;
      to_sfr_space = 1'b0;
      case (amode)
         AM_DIRECT: begin
            if (legacy_op) begin
               to_sfr_space = direct_addr[7:0] >= LEGACY_DIRECT_SFR;
               eff_addr     = {16'h0000, direct_addr[7:0]};
            end else begin
               to_sfr_space = direct_addr[23];
               eff_addr     = direct_addr[23] ? {15'h0000, direct_addr[8:0]} : direct_addr;
            end
         end
         AM_INDIRECT: eff_addr = base_reg_value;
         AM_DISPLACE: eff_addr = base_reg_value + offset;
         AM_RELATIVE: eff_addr = next_pc + offset;
         default: eff_addr = direct_addr;
      endcase
   end
endmodule

// ===== hdl/domd_decoder.sv
// Purpose: opcode map, register index and addressing mode decoder
// Assumes: fetch presents one code byte per valid cycle; ready is always taken
// Notes:   per-opcode tables are outside this block; groups only are decoded
`timescale 1ns/1ps
module domd_decoder (
   input  wire  logic                       clk_sys,
   input  wire  logic                       rst_b,
   input  wire  logic                       cfg_ext_first,
   input  wire  logic                       byte_valid,
   input  wire  logic [7:0]                 code_byte,
   input  wire  logic                       prefix_extra_fetch,
   input  wire  logic                       slow_access,
   input  wire  logic                       io_port_register,
   input  wire  logic [7:0]                 program_status_word_main,
   input  wire  logic [7:0]                 program_status_word_ext,
   input  wire  domd_pkg::domd_regkind_type dst_kind,
   input  wire  logic [5:0]                 dst_field,
   input  wire  domd_pkg::domd_regkind_type src_kind,
   input  wire  logic [5:0]                 src_field,
   input  wire  domd_pkg::domd_width_type   op_width,
   input  wire  domd_pkg::domd_amode_type   amode,
   input  wire  logic [23:0]                direct_addr,
   input  wire  logic [23:0]                base_reg_value,
   input  wire  logic [23:0]                offset,
   input  wire  logic [23:0]                next_pc,
   output logic                             byte_ready,
   output logic                             insn_valid_q,
   output domd_pkg::domd_group_type         insn_group_q,
   output logic [7:0]                       insn_opcode_q,
   output logic                             insn_prefixed_q,
   output logic                             insn_invalid_q,
   output logic [3:0]                       extra_states_q,
   output logic [5:0]                       dst_reg_q,
   output logic [5:0]                       src_reg_q,
   output logic                             dst_banked_q,
   output logic                             src_banked_q,
   output logic [1:0]                       bank_sel_q,
   output logic                             reg_index_err_q,
   output domd_pkg::domd_width_type         width_q,
   output logic [5:0]                       width_bits_q,
   output logic [23:0]                      eff_addr_q,
   output logic [7:0]                       eff_region_q,
   output logic                             to_sfr_space_q
);
   import domd_pkg::*;

   typedef enum logic [1:0] {
      ST_OPCODE  = 2'b01,
      ST_ESCAPED = 2'b10
   } domd_state_type;

   domd_state_type state_q;
   domd_map_type   map_q;
   logic           map_latched_q;
   domd_group_type group_d;
   logic           take_opcode;
   logic [23:0]    eff_addr;
   logic           to_sfr_space;
   logic [5:0]     dst_reg_d;
   logic [5:0]     src_reg_d;
   logic           dst_err;
   logic           src_err;

   ////////////////////////////////////////////////////////////////////////
   // register index decode, shared by destination and source fields
   function automatic logic [6:0] reg_decode(input domd_regkind_type kind,
                                             input logic [5:0] field);
      logic [5:0] idx;
      logic       err;
      idx = 6'h00;
      err = 1'b0;
      case (kind)
         RK_SHORT_BYTE: idx = {3'h0, field[2:0]};
         RK_WIDE_BYTE: idx = {2'h0, field[3:0]};
         RK_WORD: begin
            idx = {field[4:0], 1'b0};
            err = field[5];
         end
         RK_DWORD: begin
            idx = field;
            err = field[1:0] != 2'h0 ||
                  (field > DWORD_GEN_LAST && field != DWORD_DED_LOW &&
                   field != DWORD_DED_HIGH);
         end
         default: idx = 6'h00;
      endcase
      reg_decode = {err, idx};
   endfunction

   // columns x0h-x5h decode alike in both maps, so 14h never needs the escape
   function automatic logic low_column(input logic [7:0] b);
      low_column = b[3:0] < EXT_FIRST_VALID[3:0];
   endfunction

   function automatic logic is_banked(input domd_regkind_type kind,
                                      input logic [5:0] idx);
      case (kind)
         RK_SHORT_BYTE: is_banked = 1'b1;
         RK_WIDE_BYTE:  is_banked = idx <= BANKED_BYTE_LAST;
         RK_WORD:       is_banked = idx <= BANKED_WORD_LAST;
         RK_DWORD:      is_banked = idx <= BANKED_DWORD_LAST;
         default:       is_banked = 1'b0;
      endcase
   endfunction

   assign {dst_err, dst_reg_d} = reg_decode(dst_kind, dst_field);
   assign {src_err, src_reg_d} = reg_decode(src_kind, src_field);

   ////////////////////////////////////////////////////////////////////////
   // map selection, taken once after reset release
   // map fixed after configuration
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         map_q         <= MAP_LEGACY_FIRST;
         map_latched_q <= 1'b0;
      end else if (!map_latched_q) begin
         map_q         <= cfg_ext_first ? MAP_EXT_FIRST : MAP_LEGACY_FIRST;
         map_latched_q <= 1'b1;
      end
   end

   // stall first byte until the map is latched, so no byte sees a changing map
   assign byte_ready  = map_latched_q;
   assign take_opcode = byte_valid && map_latched_q;

   ////////////////////////////////////////////////////////////////////////
   // opcode group decode
   always_comb begin
      group_d = GRP_LEGACY_LOW;
      if (state_q == ST_ESCAPED) begin
         if (low_column(code_byte) || code_byte == ESCAPE_PREFIX) begin
            group_d = GRP_INVALID;
         end else if (map_q == MAP_LEGACY_FIRST) begin
            group_d = GRP_EXTENSION;
         end else begin
            group_d = GRP_LEGACY_HIGH;
         end
      end else if (low_column(code_byte)) begin
         // low columns same in both maps
         group_d = GRP_LEGACY_LOW;
      end else begin
         group_d = (map_q == MAP_LEGACY_FIRST) ? GRP_LEGACY_HIGH : GRP_EXTENSION;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_OPCODE;
      end else if (take_opcode) begin
         case (state_q)
            ST_OPCODE: begin
               if (code_byte == ESCAPE_PREFIX) begin
                  state_q <= ST_ESCAPED;
               end
            end
            ST_ESCAPED: state_q <= ST_OPCODE;
            default: state_q <= ST_OPCODE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // instruction result registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         insn_valid_q    <= 1'b0;
         insn_group_q    <= GRP_LEGACY_LOW;
         insn_opcode_q   <= 8'h00;
         insn_prefixed_q <= 1'b0;
         insn_invalid_q  <= 1'b0;
      end else begin
         insn_valid_q <= take_opcode &&
                         !(state_q == ST_OPCODE && code_byte == ESCAPE_PREFIX);
         if (take_opcode && !(state_q == ST_OPCODE && code_byte == ESCAPE_PREFIX)) begin
            insn_group_q    <= group_d;
            insn_opcode_q   <= code_byte;
            insn_prefixed_q <= state_q == ST_ESCAPED;
            insn_invalid_q  <= group_d == GRP_INVALID;
         end
      end
   end

   // extra states: prefix fetch, slow targets and port registers add time
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         extra_states_q <= 4'h0;
      end else if (take_opcode) begin
         extra_states_q <= ((state_q == ST_ESCAPED && prefix_extra_fetch) ?
                            PREFIX_EXTRA_STATE : 4'h0) +
                           ((slow_access || io_port_register) ? SLOW_ACCESS_STATE : 4'h0);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // operand decode registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dst_reg_q       <= 6'h00;
         src_reg_q       <= 6'h00;
         dst_banked_q    <= 1'b0;
         src_banked_q    <= 1'b0;
         bank_sel_q      <= BANK_RESET;
         reg_index_err_q <= 1'b0;
         width_q         <= WID_BYTE;
         width_bits_q    <= 6'h08;
      end else if (take_opcode) begin
         dst_reg_q       <= dst_reg_d;
         src_reg_q       <= src_reg_d;
         dst_banked_q    <= is_banked(dst_kind, dst_reg_d);
         src_banked_q    <= is_banked(src_kind, src_reg_d);
         bank_sel_q      <= program_status_word_main[4:3] | program_status_word_ext[4:3];
         reg_index_err_q <= dst_err || src_err;
         width_q         <= op_width;
         case (op_width)
            WID_BIT:   width_bits_q <= 6'h01;
            WID_BYTE:  width_bits_q <= 6'h08;
            WID_WORD:  width_bits_q <= 6'h10;
            WID_DWORD: width_bits_q <= 6'h20;
            default:   width_bits_q <= 6'h08;
         endcase
      end
   end

   domd_addr_unit u_addr (
      .amode          (amode),
      .legacy_op      (group_d != GRP_EXTENSION),
      .direct_addr    (direct_addr),
      .base_reg_value (base_reg_value),
      .offset         (offset),
      .next_pc        (next_pc),
      .eff_addr       (eff_addr),
      .to_sfr_space   (to_sfr_space)
   );

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         eff_addr_q     <= 24'h000000;
         eff_region_q   <= REGION_ZERO;
         to_sfr_space_q <= 1'b0;
      end else if (take_opcode) begin
         eff_addr_q     <= eff_addr;
         eff_region_q   <= to_sfr_space ? REGION_ZERO : eff_addr[23:16];
         to_sfr_space_q <= to_sfr_space;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_escape_then_byte;
      take_opcode && state_q == ST_OPCODE && code_byte == ESCAPE_PREFIX
      ##1 take_opcode;
   endsequence

   property p_map_fixed;
      @(posedge clk_sys) disable iff (!rst_b)
         map_latched_q |=> $stable(map_q);
   endproperty
   a_map_fixed: assert property (p_map_fixed) else $error("map changed");

   property p_single_legacy;
      @(posedge clk_sys) disable iff (!rst_b)
         take_opcode && state_q == ST_OPCODE && code_byte != ESCAPE_PREFIX &&
         map_q == MAP_LEGACY_FIRST |=> insn_valid_q && !insn_prefixed_q &&
         insn_group_q != GRP_EXTENSION;
   endproperty
   a_single_legacy: assert property (p_single_legacy) else $error("legacy single");

   property p_escape_no_insn;
      @(posedge clk_sys) disable iff (!rst_b)
         take_opcode && state_q == ST_OPCODE && code_byte == ESCAPE_PREFIX |=> !insn_valid_q;
   endproperty
   a_escape_no_insn: assert property (p_escape_no_insn) else $error("escape issued");

   property p_swap;
      @(posedge clk_sys) disable iff (!rst_b)
         take_opcode && state_q == ST_OPCODE && !low_column(code_byte) &&
         code_byte != ESCAPE_PREFIX && map_q == MAP_EXT_FIRST |=>
         insn_group_q == GRP_EXTENSION;
   endproperty
   a_swap: assert property (p_swap) else $error("swap wrong");

   property p_reserved;
      @(posedge clk_sys) disable iff (!rst_b)
         take_opcode && state_q == ST_ESCAPED && low_column(code_byte) |=>
         insn_invalid_q && insn_prefixed_q;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved accepted");

   property p_prefixed_after_escape;
      @(posedge clk_sys) disable iff (!rst_b)
         s_escape_then_byte |=> insn_valid_q && insn_prefixed_q;
   endproperty
   a_prefixed_after_escape: assert property (p_prefixed_after_escape)
      else $error("prefix lost");

   property p_word_even;
      @(posedge clk_sys) disable iff (!rst_b)
         take_opcode && dst_kind == RK_WORD |=> !dst_reg_q[0] && dst_reg_q <= WORD_LAST;
   endproperty
   a_word_even: assert property (p_word_even) else $error("odd word reg");

   property p_short_byte;
      @(posedge clk_sys) disable iff (!rst_b)
         take_opcode && src_kind == RK_SHORT_BYTE |=> src_reg_q <= BANKED_BYTE_LAST;
   endproperty
   a_short_byte: assert property (p_short_byte) else $error("short byte range");

   property p_width;
      @(posedge clk_sys) disable iff (!rst_b)
         take_opcode && op_width == WID_DWORD |=> width_bits_q == 6'h20;
   endproperty
   a_width: assert property (p_width) else $error("width bits");

   property p_sfr_region;
      @(posedge clk_sys) disable iff (!rst_b)
         to_sfr_space_q |-> eff_region_q == REGION_ZERO && eff_addr_q <= {15'h0, SFR_SPACE_LAST};
   endproperty
   a_sfr_region: assert property (p_sfr_region) else $error("sfr address");
endmodule

// ===== test/domd_fetch_model.sv
// Purpose: fetch stage stand-in that offers code bytes to the decoder
// Assumes: a byte is taken at a rising edge with byte_ready high
// Notes:   an idle bus shows the inverted last byte, never stale data
`timescale 1ns/1ps
module domd_fetch_model (
   input  wire logic       clk_sys,
   input  wire logic       byte_ready,
   output logic            byte_valid,
   output logic [7:0]      code_byte
);
   initial begin
      byte_valid = 1'b0;
      code_byte  = 8'h5a;
   end
   ////////////////////////////////////////////////////////////
   // hold the byte until taken; hold keeps valid up for a pair
   task automatic put(input logic [7:0] b, input logic hold);
      int n;
      n = 0;
      byte_valid <= 1'b1;
      code_byte  <= b;
      do begin
         @(posedge clk_sys);
         n++;
      end while (!byte_ready && n < 50);
      if (!hold) begin
         byte_valid <= 1'b0;
         code_byte  <= ~b;
      end
   endtask
endmodule

// ===== test/test_dual_opcode_map_decoder.sv
// Purpose: self-checking bench for the dual opcode map decoder
// Assumes: decoder answers one cycle after the final opcode byte
// Notes:   scenarios are tasks; each judges its own results
`timescale 1ns/1ps
module test_dual_opcode_map_decoder;
   import domd_pkg::*;
   logic clk_sys, rst_b, cfg_ext_first, byte_valid, byte_ready;
   logic prefix_extra_fetch, slow_access, io_port_register;
   logic [7:0] code_byte, program_status_word_main, program_status_word_ext;
   domd_regkind_type dst_kind, src_kind;
   logic [5:0] dst_field, src_field, dst_reg_q, src_reg_q, width_bits_q;
   domd_width_type op_width, width_q;
   domd_amode_type amode;
   domd_group_type insn_group_q;
   logic [23:0] direct_addr, base_reg_value, offset, next_pc, eff_addr_q;
   logic insn_valid_q, insn_prefixed_q, insn_invalid_q, dst_banked_q, src_banked_q;
   logic reg_index_err_q, to_sfr_space_q;
   logic [7:0] insn_opcode_q, eff_region_q;
   logic [3:0] extra_states_q;
   logic [1:0] bank_sel_q;
   int failures, checks_done, cycles;

   domd_decoder dut (.clk_sys(clk_sys), .rst_b(rst_b), .cfg_ext_first(cfg_ext_first),
      .byte_valid(byte_valid), .code_byte(code_byte), .prefix_extra_fetch(prefix_extra_fetch),
      .slow_access(slow_access), .io_port_register(io_port_register),
      .program_status_word_main(program_status_word_main),
      .program_status_word_ext(program_status_word_ext), .dst_kind(dst_kind),
      .dst_field(dst_field), .src_kind(src_kind), .src_field(src_field), .op_width(op_width),
      .amode(amode), .direct_addr(direct_addr), .base_reg_value(base_reg_value),
      .offset(offset), .next_pc(next_pc), .byte_ready(byte_ready), .insn_valid_q(insn_valid_q),
      .insn_group_q(insn_group_q), .insn_opcode_q(insn_opcode_q),
      .insn_prefixed_q(insn_prefixed_q), .insn_invalid_q(insn_invalid_q),
      .extra_states_q(extra_states_q), .dst_reg_q(dst_reg_q), .src_reg_q(src_reg_q),
      .dst_banked_q(dst_banked_q), .src_banked_q(src_banked_q), .bank_sel_q(bank_sel_q),
      .reg_index_err_q(reg_index_err_q), .width_q(width_q), .width_bits_q(width_bits_q),
      .eff_addr_q(eff_addr_q), .eff_region_q(eff_region_q), .to_sfr_space_q(to_sfr_space_q));
   domd_fetch_model fetch (.clk_sys(clk_sys), .byte_ready(byte_ready),
      .byte_valid(byte_valid), .code_byte(code_byte));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // hang guard, well above the roughly 160 cycles the tests need
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         finish_test;
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic do_reset(input logic ext);
      rst_b <= 1'b0;
      cfg_ext_first <= ext;
      repeat (12) @(posedge clk_sys);
      chk("ready_in_reset", 0, byte_ready); // map not latched yet
      rst_b <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk("ready", 1, byte_ready); // map latched
   endtask
   // escape first when prefixed, then look just after the answer lands
   task automatic issue(input logic pre, input logic [7:0] b);
      if (pre) fetch.put(ESCAPE_PREFIX, 1'b1);
      fetch.put(b, 1'b0);
      #1;
      chk("insn_valid", 1, insn_valid_q); // answer after final byte
   endtask
   ////////////////////////////////////////////////////////////
   task automatic test_map(input logic ext);
      logic [7:0] tab [6] = '{8'h00, 8'h05, 8'h06, 8'h14, 8'h9c, 8'ha5};
      domd_group_type g;
      logic [3:0] col;
      do_reset(ext);
      cfg_ext_first <= ~ext; // strap moves, map must not
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 6; i++) begin
            if (p == 0 && tab[i] == ESCAPE_PREFIX) continue;
            col = tab[i][3:0];
            if (p == 1 && (col < EXT_FIRST_VALID[3:0] || tab[i] == ESCAPE_PREFIX)) g = GRP_INVALID;
            else if (p == 0 && col < EXT_FIRST_VALID[3:0]) g = GRP_LEGACY_LOW;
            else if ((p == 1) != ext) g = GRP_EXTENSION;
            else g = GRP_LEGACY_HIGH;
            issue(p[0], tab[i]);
            chk("group", g, insn_group_q); // group
            chk("prefixed", p[0], insn_prefixed_q); // escape seen
            chk("invalid", g == GRP_INVALID, insn_invalid_q); // reserved flagged
            chk("opcode", tab[i], insn_opcode_q); // opcode kept
            @(posedge clk_sys);
         end
      end
      $display("test map %0d done", ext);
   endtask
   task automatic test_states;
      prefix_extra_fetch <= 1'b1;
      issue(1'b1, 8'h9c);
      chk("extra", 4'h1, extra_states_q); // prefix fetch state
      @(posedge clk_sys);
      slow_access <= 1'b1;
      issue(1'b1, 8'h9c);
      chk("extra", 4'h2, extra_states_q); // slow access adds
      @(posedge clk_sys);
      prefix_extra_fetch <= 1'b0;
      slow_access <= 1'b0;
      io_port_register <= 1'b1;
      issue(1'b0, 8'h9c);
      chk("extra", 4'h1, extra_states_q); // port register adds
      @(posedge clk_sys);
      io_port_register <= 1'b0;
      issue(1'b1, 8'h9c);
      chk("extra", 4'h0, extra_states_q); // no extra fetch
      @(posedge clk_sys);
      $display("test states done");
   endtask
   task automatic reg_case(input domd_regkind_type dk, input logic [5:0] df,
      input domd_regkind_type sk, input logic [5:0] sf, input logic [5:0] ed,
      input logic [5:0] es, input logic bd, input logic bs, input logic er);
      dst_kind <= dk;
      dst_field <= df;
      src_kind <= sk;
      src_field <= sf;
      issue(1'b1, 8'h30);
      chk("index_err", er, reg_index_err_q); // bad dword index
      if (!er) begin
         chk("dst_reg", ed, dst_reg_q); // index
         chk("src_reg", es, src_reg_q); // source second
         chk("dst_banked", bd, dst_banked_q); // low bank
         chk("src_banked", bs, src_banked_q); // low bank
      end
      @(posedge clk_sys);
   endtask
   task automatic test_regs;
      logic [5:0] bits [4] = '{6'd1, 6'd8, 6'd16, 6'd32};
      program_status_word_main <= 8'h18;
      reg_case(RK_WORD, 6'h0f, RK_WORD, 6'h00, 6'h1e, 6'h00, 1'b0, 1'b1, 1'b0);
      chk("bank", 2'h3, bank_sel_q); // bank from status
      reg_case(RK_DWORD, 6'h3c, RK_DWORD, 6'h1c, 6'h3c, 6'h1c, 1'b0, 1'b0, 1'b0);
      reg_case(RK_SHORT_BYTE, 6'h07, RK_WIDE_BYTE, 6'h0f, 6'h07, 6'h0f, 1'b1, 1'b0, 1'b0);
      reg_case(RK_WORD, 6'h04, RK_WIDE_BYTE, 6'h08, 6'h08, 6'h08, 1'b0, 1'b0, 1'b0);
      reg_case(RK_DWORD, 6'h05, RK_WORD, 6'h01, 6'h00, 6'h00, 1'b0, 1'b0, 1'b1);
      for (int w = 0; w < 4; w++) begin
         op_width <= domd_width_type'(w);
         issue(1'b1, 8'h30);
         chk("width", w, width_q); // width code
         chk("width_bits", bits[w], width_bits_q); // width size
         @(posedge clk_sys);
      end
      $display("test regs done");
   endtask
   task automatic addr_case(input logic pre, input domd_amode_type am, input logic [23:0] a,
      input logic [23:0] o, input logic s);
      logic [23:0] e;
      amode <= am;
      direct_addr <= a;
      base_reg_value <= a;
      next_pc <= a ^ 24'h0f0000;
      offset <= o;
      issue(pre, 8'h7c);
      chk("to_sfr", s, to_sfr_space_q); // space split
      if (am == AM_DIRECT) e = !pre ? {16'h0000, a[7:0]} : s ? {15'h0000, a[8:0]} : a;
      else e = (am == AM_INDIRECT) ? a : (am == AM_DISPLACE) ? a + o : (a ^ 24'h0f0000) + o;
      chk("eff_addr", e, eff_addr_q); // forming
      chk("region", s ? 8'h00 : e[23:16], eff_region_q); // region byte
      @(posedge clk_sys);
   endtask
   task automatic test_addr;
      addr_case(1'b0, AM_DIRECT, 24'h000090, 24'h0, 1'b1);
      addr_case(1'b0, AM_DIRECT, 24'h000040, 24'h0, 1'b0);
      addr_case(1'b0, AM_INDIRECT, 24'h000090, 24'h0, 1'b0);
      addr_case(1'b1, AM_DIRECT, 24'h800090, 24'h0, 1'b1);
      addr_case(1'b1, AM_DIRECT, 24'h000090, 24'h0, 1'b0);
      addr_case(1'b1, AM_DISPLACE, 24'h12fff0, 24'h000021, 1'b0);
      addr_case(1'b1, AM_RELATIVE, 24'h001000, 24'hfffffe, 1'b0);
      $display("test addr done");
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      rst_b = 1'b0;
      cfg_ext_first = 1'b0;
      prefix_extra_fetch = 1'b0;
      slow_access = 1'b0;
      io_port_register = 1'b0;
      program_status_word_main = 8'h00;
      program_status_word_ext = 8'h00;
      dst_kind = RK_SHORT_BYTE;
      src_kind = RK_SHORT_BYTE;
      dst_field = 6'h00;
      src_field = 6'h00;
      op_width = WID_BYTE;
      amode = AM_REGISTER;
      direct_addr = 24'h000000;
      base_reg_value = 24'h000000;
      offset = 24'h000000;
      next_pc = 24'h000000;
      failures = 0;
      checks_done = 0;
      cycles = 0;
      do_reset(1'b0);
      chk("reset_width", WID_BYTE, width_q);
      chk("reset_bits", 6'd8, width_bits_q);
      chk("reset_valid", 0, insn_valid_q);
      $display("test reset done");
      test_map(1'b0);
      test_states;
      test_regs;
      test_addr;
      test_map(1'b1);
      finish_test;
   end
endmodule
